// file: verilog/tdm_slot_routing_config.sv
// Register bank and slot routing for the serial subscriber bus
//
// Design decision made here: register access over Wishbone.
`default_nettype none
module tdm_slot_routing_config
    import tdm_cfg_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [2:0] chan_select_pins_i,
    input wire logic frame_sync_i,
    input wire logic bus_data_clock_i,
    input wire logic bit_clock_i,
    input wire logic upstream_line_i,
    input wire logic downstream_line_i,
    input wire logic up_tx_data_i,
    input wire logic down_tx_data_i,
    input wire logic terminal_mode_i,
    input wire logic dc_is_input_i,
    output logic upstream_line_o,
    output logic upstream_line_oe_o,
    output logic downstream_line_o,
    output logic downstream_line_oe_o,
    output logic frame_sync_oe_o,
    output logic bus_data_clock_oe_o,
    output logic activation_req_o,
    output logic strobe_one_o,
    output logic strobe_two_o,
    output logic bit_clock_out_o,
    output logic bit_clock_double_o,
    output logic awake_disable_o,
    output logic bchan_octet1_act_o,
    output logic bchan_octet2_act_o,
    output logic bchan_short_act_o,
    output logic bchan_rx_o,
    output logic dchan_act_o,
    output logic dchan_rx_o,
    output logic code0_act_o,
    output logic code0_rx_o,
    output logic code1_act_o,
    output logic code1_rx_o,
    output logic supervision_act_o,
    output logic supervision_rx_o,
    output logic arbitration_slot_o
);
    import tdm_cfg_pkg::*;

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic [7:0] strobe_one_control;
        logic [7:0] strobe_two_control;
        logic [7:0] bchan_slot_control;
        logic [7:0] dchan_ci1_control;
        logic [7:0] ci0_handler_control;
        logic [7:0] supervision_control;
        logic [7:0] bus_global_control;
        logic [7:0] octet_one;
        logic [7:0] octet_two;
        logic [7:0] strobe_config;
        logic pins_pending;
        logic ack;
        logic [31:0] rdata;
        logic up_o;
        logic up_oe;
        logic dn_o;
        logic dn_oe;
        logic fs_oe;
        logic dc_oe;
        logic act_req;
        logic str1;
        logic str2;
        logic bit_clock_out;
        logic bcl_dbl;
        logic aw_dis;
        logic [13:0] route;
        logic arb;
    } state_t;
    state_t st, next_st;

    // ----------------------------------------
    // Pin synchronisers and slot timing
    // ----------------------------------------
    logic fs_q, fs_rise, dcl_q, bit_q, bit_fall, up_q, dn_q;
    logic [4:0] slot;
    logic [2:0] bitpos;
    logic [2:0] pins_s1, pins_s2;

    edge_sync u_fs (.clk_i(clk_i), .rst_i(rst_i), .d_i(frame_sync_i), .q_o(fs_q), .rise_o(fs_rise), .fall_o());
    edge_sync u_dcl (.clk_i(clk_i), .rst_i(rst_i), .d_i(bus_data_clock_i), .q_o(dcl_q), .rise_o(), .fall_o());
    edge_sync u_bcl (.clk_i(clk_i), .rst_i(rst_i), .d_i(bit_clock_i), .q_o(bit_q), .rise_o(), .fall_o(bit_fall));
    edge_sync u_up (.clk_i(clk_i), .rst_i(rst_i), .d_i(upstream_line_i), .q_o(up_q), .rise_o(), .fall_o());
    edge_sync u_dn (.clk_i(clk_i), .rst_i(rst_i), .d_i(downstream_line_i), .q_o(dn_q), .rise_o(), .fall_o());

    slot_timer u_tmr (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .bit_edge_i(bit_fall),
        .frame_i(fs_rise),
        .slot_o(slot),
        .bit_o(bitpos)
    );

    // Straps caught after release, so reset takes only constants
    always_ff @(posedge clk_i) begin
        pins_s1 <= chan_select_pins_i;
        pins_s2 <= pins_s1;
    end

    // ----------------------------------------
    // Decode helpers
    // ----------------------------------------
    function automatic logic lane_byte(input logic [3:0] sel, input logic [31:0] d, output logic [7:0] b);
        b = d[7:0];
        return sel[0];
    endfunction

    // Short slot: bits 7,6 of slot 4n+3
    function automatic logic in_short(input logic [4:0] s, input logic [2:0] b, input logic [2:0] ch);
        return (s == {ch, 2'b11}) && (b[2:1] == 2'b11);
    endfunction

    function automatic logic in_octets(input logic [4:0] s, input logic [2:0] ch, input logic e1, input logic e2);
        return (e1 && s == {ch, 2'b00}) || (e2 && s == {ch, 2'b01});
    endfunction

    function automatic logic strobe_hit(input logic [7:0] c, input logic [4:0] s, input logic [2:0] b);
        logic [4:0] base;
        base = c[ST_IDX_LSB +: ST_IDX_W];
        return (c[ST_SLOT_EN] && s == base)
            || (c[ST_NEXT_EN] && s == 5'(base + 5'h01))
            || (c[ST_SHORT_EN] && s == 5'(base + 5'h03) && b[2:1] == 2'b11);
    endfunction

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    logic req, wr, rd, view;
    logic [7:0] wb;
    logic [7:0] rv;
    logic [2:0] d_ch, c0_ch, b_ch, sv_ch;
    logic b_act1, b_act2, b_shrt, d_act, c0_act, c1_act, sv_act;

    always_comb begin
        next_st = st;
        wb = 8'h00;
        rv = 8'h00;
        req = wb_cyc_i && wb_stb_i && !st.ack;
        wr = req && wb_we_i && lane_byte(wb_sel_i, wb_dat_i, wb);
        rd = req && !wb_we_i;
        view = st.bus_global_control[BG_VIEW];
        next_st.ack = req;

        if (st.pins_pending) begin
            next_st.pins_pending = 1'b0;
            next_st.bchan_slot_control[CS_LSB +: CS_W] = pins_s2;
            next_st.dchan_ci1_control[CS_LSB +: CS_W] = pins_s2;
            next_st.ci0_handler_control[CS_LSB +: CS_W] = pins_s2;
            next_st.supervision_control[CS_LSB +: CS_W] = pins_s2;
        end

        if (wr) begin
            unique case (wb_adr_i)
                OFS_STROBE_ONE: next_st.strobe_one_control = wb;
                OFS_STROBE_TWO: next_st.strobe_two_control = wb;
                OFS_BCHAN: next_st.bchan_slot_control = wb;
                OFS_BCTL_OCTET_ONE: next_st.octet_one = wb;
                OFS_BCTL_OCTET_TWO: next_st.octet_two = wb;
                OFS_STROBE_CONFIG: next_st.strobe_config = wb;
                OFS_SUPERVISION: next_st.supervision_control = wb;
                OFS_BUS_GLOBAL: next_st.bus_global_control = wb;
                OFS_DCHAN_CI1: begin
                    if (!view) begin
                        next_st.dchan_ci1_control = wb;
                        next_st.ci0_handler_control[CS_LSB +: CS_W] = wb[CS_LSB +: CS_W];
                    end else begin
                        next_st.ci0_handler_control = {5'h00, wb[CS_LSB +: CS_W]};
                    end
                end
                default: ;
            endcase
        end

        unique case (wb_adr_i)
            OFS_STROBE_ONE: rv = st.strobe_one_control;
            OFS_STROBE_TWO: rv = st.strobe_two_control;
            OFS_BCHAN: rv = st.bchan_slot_control;
            OFS_BCTL_OCTET_ONE: rv = st.octet_one;
            OFS_BCTL_OCTET_TWO: rv = st.octet_two;
            OFS_STROBE_CONFIG: rv = st.strobe_config;
            OFS_SUPERVISION: rv = st.supervision_control;
            OFS_BUS_GLOBAL: rv = st.bus_global_control;
            OFS_DCHAN_CI1: rv = view ? st.ci0_handler_control : st.dchan_ci1_control;
            default: rv = 8'h00;
        endcase
        next_st.rdata = rd ? {24'h000000, rv} : 32'h00000000;

        // ----------------------------------------
        // Slot routing
        // ----------------------------------------
        b_ch = st.bchan_slot_control[CS_LSB +: CS_W];
        d_ch = st.dchan_ci1_control[CS_LSB +: CS_W];
        c0_ch = st.ci0_handler_control[CS_LSB +: CS_W];
        sv_ch = st.supervision_control[CS_LSB +: CS_W];
        // B octet positions are full slot indices, not channel based
        b_act1 = st.bchan_slot_control[BC_OCT1_EN] && slot == st.octet_one[4:0];
        b_act2 = st.bchan_slot_control[BC_OCT2_EN] && slot == st.octet_two[4:0];
        b_shrt = st.bchan_slot_control[BC_SHORT_EN] && in_short(slot, bitpos, b_ch);
        d_act = in_octets(slot, d_ch, st.dchan_ci1_control[DC_OCT1_EN], st.dchan_ci1_control[DC_OCT2_EN])
            || (st.dchan_ci1_control[DC_SHORT_EN] && in_short(slot, bitpos, d_ch));
        c0_act = (slot == {c0_ch, 2'b11}) && (bitpos[2:1] != 2'b11) && (bitpos != 3'h0);
        c1_act = st.dchan_ci1_control[DC_C1_EN] && slot == 5'h07 && bitpos[2:1] != 2'b11;
        sv_act = st.supervision_control[SV_EN] && slot == 5'({sv_ch, 2'b00} + SUPV_BASE);
        // Arbitration octet collides with channel 2 routing unless freed
        if (!st.bus_global_control[BG_ARB_OFF] && slot == 5'(ARB_SLOT)) begin
            d_act = 1'b0;
        end
        next_st.route = {b_act1, b_act2, b_shrt, st.bchan_slot_control[BC_DIR], d_act, 1'b0,
            c0_act, 1'b0, c1_act, st.dchan_ci1_control[DC_C1_DIR], sv_act, st.supervision_control[SV_DIR],
            1'b0, 1'b0};
        next_st.arb = !st.bus_global_control[BG_ARB_OFF] && slot == 5'(ARB_SLOT);

        // ----------------------------------------
        // Line drivers
        // ----------------------------------------
        if (st.bus_global_control[BG_BUS_DIS]) begin
            next_st.fs_oe = 1'b0;
            next_st.dc_oe = 1'b0;
            next_st.dn_oe = 1'b0;
            next_st.dn_o = 1'b0;
            next_st.up_oe = 1'b0;
            next_st.up_o = 1'b0;
            next_st.act_req = !terminal_mode_i && !up_q;
        end else begin
            next_st.fs_oe = !dc_is_input_i;
            next_st.dc_oe = !dc_is_input_i;
            next_st.act_req = 1'b0;
            if (st.bus_global_control[BG_WAKE]) begin
                next_st.up_o = 1'b0;
                next_st.up_oe = 1'b1;
            end else if (st.bus_global_control[BG_PUSH_PULL]) begin
                next_st.up_o = up_tx_data_i;
                next_st.up_oe = 1'b1;
            end else begin
                next_st.up_o = 1'b0;
                next_st.up_oe = !up_tx_data_i;
            end
            next_st.dn_o = st.bus_global_control[BG_PUSH_PULL] ? down_tx_data_i : 1'b0;
            next_st.dn_oe = st.bus_global_control[BG_PUSH_PULL] || !down_tx_data_i;
        end

        // ----------------------------------------
        // Strobes and bit clock
        // ----------------------------------------
        next_st.str1 = strobe_hit(st.strobe_one_control, slot, bitpos)
            && (st.strobe_config[SC_ONE_BCL] ? bit_q : 1'b1);
        next_st.str2 = strobe_hit(st.strobe_two_control, slot, bitpos)
            && (st.strobe_config[SC_TWO_BCL] ? bit_q : 1'b1);
        next_st.bit_clock_out = st.bus_global_control[BG_BCL_EN] && bit_q;
        next_st.bcl_dbl = !st.bus_global_control[BG_CLK_RATE] && dcl_q;
        next_st.aw_dis = st.bus_global_control[BG_AW_DIS];
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= '0;
            st.strobe_one_control <= RST_STROBE;
            st.strobe_two_control <= RST_STROBE;
            st.bchan_slot_control <= RST_BCHAN;
            st.dchan_ci1_control <= RST_DCHAN_CI1;
            st.ci0_handler_control <= RST_CI0;
            st.supervision_control <= RST_SUPERVISION;
            st.bus_global_control <= RST_BUS_GLOBAL;
            st.octet_one <= RST_BCTL_OCTET_ONE;
            st.octet_two <= RST_BCTL_OCTET_TWO;
            st.strobe_config <= RST_STROBE_CONFIG;
            st.pins_pending <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign wb_dat_o = st.rdata;
    assign wb_ack_o = st.ack;
    assign upstream_line_o = st.up_o;
    assign upstream_line_oe_o = st.up_oe;
    assign downstream_line_o = st.dn_o;
    assign downstream_line_oe_o = st.dn_oe;
    assign frame_sync_oe_o = st.fs_oe;
    assign bus_data_clock_oe_o = st.dc_oe;
    assign activation_req_o = st.act_req;
    assign strobe_one_o = st.str1;
    assign strobe_two_o = st.str2;
    assign bit_clock_out_o = st.bit_clock_out;
    assign bit_clock_double_o = st.bcl_dbl;
    assign awake_disable_o = st.aw_dis;
    assign bchan_octet1_act_o = st.route[13];
    assign bchan_octet2_act_o = st.route[12];
    assign bchan_short_act_o = st.route[11];
    assign bchan_rx_o = st.route[10];
    assign dchan_act_o = st.route[9];
    assign dchan_rx_o = st.route[8];
    assign code0_act_o = st.route[7];
    assign code0_rx_o = st.route[6];
    assign code1_act_o = st.route[5];
    assign code1_rx_o = st.route[4];
    assign supervision_act_o = st.route[3];
    assign supervision_rx_o = st.route[2];
    assign arbitration_slot_o = st.arb;
endmodule : tdm_slot_routing_config
`default_nettype wire

// file: verilog/tdm_cfg_pkg.sv
// Constants, register map and field layout for the slot routing configuration block
// How it works
// - B controller: two octet slots, one short slot, own enables.
// - B short slot direction 0: out downstream, in upstream; 1 swaps.
// - B control channel select picks one of eight channels for its short slot.
// - After reset channel select fields load from the three pins.
// - D/code1 register accessible only while view select is 0.
// - Code1 handler: fixed channel 1 slot, enable gates, direction steers.
// - D controller takes enabled octets and short slot of its channel.
// - View 0: D channel select write also writes code0 select.
// - Code0 register always writable, readable only at view 1.
// - Code0 select picks the channel of its code0 slot.
// - Supervision enable gates both directions; direction bit steers.
// - Supervision channel code n places supervision data in slot 4n+3.
// - Strobe active in slot, next slot, and bits 7,6 of slot+3, each enabled.
// - Five-bit index picks 1 of 32 slots; strobe high or clock.
// - Soft wakeup at 1 holds upstream low; at 0 upstream carries data.
// - Awake disable at 1 turns off transceiver asynchronous awake.
// - View 0: select writes hit D and code0, reads D; view 1: code0 only.
// - Bit clock out runs only when enabled; rate select 0 puts data clock on the double-rate output, 1 holds it low.
// - Push-pull select 0 makes data outputs open drain, 1 push pull.
// - Bus disable floats sync, clock and both data lines; upstream low wakes unless in terminal mode.
// - B octet positions come from slot registers; short slot from B control.
// - Strobe clock option 1 puts bit clock in strobe slots.
`default_nettype none
package tdm_cfg_pkg;
    localparam logic [7:0] OFS_STROBE_ONE = 8'h55;
    localparam logic [7:0] OFS_STROBE_TWO = 8'h56;
    localparam logic [7:0] OFS_BCHAN = 8'h51;
    localparam logic [7:0] OFS_DCHAN_CI1 = 8'h52;
    localparam logic [7:0] OFS_SUPERVISION = 8'h53;
    localparam logic [7:0] OFS_BUS_GLOBAL = 8'h57;
    localparam logic [7:0] OFS_BCTL_OCTET_ONE = 8'h48;
    localparam logic [7:0] OFS_BCTL_OCTET_TWO = 8'h49;
    localparam logic [7:0] OFS_STROBE_CONFIG = 8'h5A;
    localparam logic [7:0] RST_STROBE = 8'h00;
    localparam logic [7:0] RST_BCHAN = 8'h08;
    localparam logic [7:0] RST_DCHAN_CI1 = 8'hA0;
    localparam logic [7:0] RST_CI0 = 8'h00;
    localparam logic [7:0] RST_SUPERVISION = 8'h40;
    localparam logic [7:0] RST_BUS_GLOBAL = 8'h08;
    localparam logic [7:0] RST_BCTL_OCTET_ONE = 8'h80;
    localparam logic [7:0] RST_BCTL_OCTET_TWO = 8'h81;
    localparam logic [7:0] RST_STROBE_CONFIG = 8'h00;
    // Channel select field, shared by B, D, code0 and supervision registers
    localparam int CS_LSB = 0;
    localparam int CS_W = 3;
    // B control
    localparam int BC_DIR = 7;
    localparam int BC_SHORT_EN = 5;
    localparam int BC_OCT2_EN = 4;
    localparam int BC_OCT1_EN = 3;
    // D and code1 control
    localparam int DC_C1_DIR = 7;
    localparam int DC_C1_EN = 6;
    localparam int DC_SHORT_EN = 5;
    localparam int DC_OCT2_EN = 4;
    localparam int DC_OCT1_EN = 3;
    // Supervision control
    localparam int SV_DIR = 7;
    localparam int SV_EN = 6;
    // Strobe control
    localparam int ST_SLOT_EN = 7;
    localparam int ST_NEXT_EN = 6;
    localparam int ST_SHORT_EN = 5;
    localparam int ST_IDX_LSB = 0;
    localparam int ST_IDX_W = 5;
    // Strobe config: bit clock option per strobe
    localparam int SC_ONE_BCL = 0;
    localparam int SC_TWO_BCL = 1;
    // Octet slot register: direction and slot index
    localparam int OS_DIR = 7;
    // Bus global control
    localparam int BG_WAKE = 7;
    localparam int BG_AW_DIS = 6;
    localparam int BG_VIEW = 5;
    localparam int BG_ARB_OFF = 4;
    localparam int BG_BCL_EN = 3;
    localparam int BG_CLK_RATE = 2;
    localparam int BG_PUSH_PULL = 1;
    localparam int BG_BUS_DIS = 0;
    // Frame geometry
    localparam int SLOTS = 32;
    localparam int ARB_SLOT = 11;
    localparam logic [4:0] SUPV_BASE = 5'h03;
endpackage : tdm_cfg_pkg
`default_nettype wire

// file: verilog/edge_sync.sv
// Two-flop synchroniser with rising and falling edge pulses
`default_nettype none
module edge_sync (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic d_i,
    output logic q_o,
    output logic rise_o,
    output logic fall_o
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } state_t;
    state_t st, next_st;
    always_comb begin
        next_st = st;
        next_st.s1 = d_i;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
    assign q_o = st.s2;
    assign rise_o = st.s2 & ~st.s3;
    assign fall_o = ~st.s2 & st.s3;
endmodule : edge_sync
`default_nettype wire

// file: verilog/slot_timer.sv
// Slot and bit position counter driven by frame sync and bit clock edges
`default_nettype none
module slot_timer (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic bit_edge_i,
    input wire logic frame_i,
    output logic [4:0] slot_o,
    output logic [2:0] bit_o
);
    typedef struct packed {
        logic [4:0] slot;
        logic [2:0] bitpos;
    } state_t;
    state_t st, next_st;
    always_comb begin
        next_st = st;
        if (frame_i) begin
            next_st.slot = 5'h00;
            next_st.bitpos = 3'h7;
        end else if (bit_edge_i) begin
            next_st.bitpos = st.bitpos - 3'h1;
            if (st.bitpos == 3'h0) begin
                next_st.slot = st.slot + 5'h01;
            end
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
    assign slot_o = st.slot;
    assign bit_o = st.bitpos;
endmodule : slot_timer
`default_nettype wire

// file: testbench/tdm_slot_routing_config_monitor.sv
// Port checker for the slot routing configuration block
`default_nettype none
module tdm_slot_routing_config_monitor
    import tdm_cfg_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic upstream_line_o,
    input wire logic upstream_line_oe_o,
    input wire logic downstream_line_o,
    input wire logic downstream_line_oe_o,
    input wire logic frame_sync_oe_o,
    input wire logic bus_data_clock_oe_o,
    input wire logic bit_clock_out_o,
    input wire logic awake_disable_o,
    input wire logic supervision_act_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] g;
    logic take;
    // Global byte shadow; outputs trail it by one cycle
    assign take = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            g <= RST_BUS_GLOBAL;
        end else if (take && wb_adr_i == OFS_BUS_GLOBAL) begin
            g <= wb_dat_i[7:0];
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("late ack");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("long ack");
    a_dat_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
        else $error("upper data set");
    a_wake_low: assert property (g[BG_WAKE] && $past(g[BG_WAKE], 2) |-> upstream_line_oe_o && !upstream_line_o)
        else $error("wake not low");
    a_awake_follow: assert property (g[BG_AW_DIS] == $past(g[BG_AW_DIS], 2) |-> awake_disable_o == g[BG_AW_DIS])
        else $error("awake mismatch");
    a_open_drain: assert property (!g[BG_PUSH_PULL] && !$past(g[BG_PUSH_PULL], 2)
        |-> !(downstream_line_oe_o && downstream_line_o) && !(upstream_line_oe_o && upstream_line_o))
        else $error("drove high in open drain");
    a_bus_float: assert property (g[BG_BUS_DIS] && $past(g[BG_BUS_DIS], 2)
        |-> !frame_sync_oe_o && !bus_data_clock_oe_o && !downstream_line_oe_o)
        else $error("drove while disabled");
    a_bcl_gate: assert property (!g[BG_BCL_EN] && !$past(g[BG_BCL_EN], 2) |-> !bit_clock_out_o)
        else $error("bit clock while off");
    c_write: cover property (wb_ack_o && wb_we_i);
    c_supv: cover property (supervision_act_o);
    c_wake: cover property (g[BG_WAKE] && !upstream_line_o);
endmodule // tdm_slot_routing_config_monitor
bind tdm_slot_routing_config tdm_slot_routing_config_monitor i_tdm_slot_routing_config_monitor (.clk_i, .rst_i,
    .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .upstream_line_o,
    .upstream_line_oe_o, .downstream_line_o, .downstream_line_oe_o, .frame_sync_oe_o, .bus_data_clock_oe_o,
    .bit_clock_out_o, .awake_disable_o, .supervision_act_o);
`default_nettype wire

// file: testbench/tdm_far_side_model.sv
// Far-side bus model: frame timing and pulled-up data lines
`default_nettype none
module tdm_far_side_model (
    input wire logic run_i,
    input wire logic up_drv_i,
    input wire logic up_oe_i,
    input wire logic dn_drv_i,
    input wire logic dn_oe_i,
    output logic frame_sync_o,
    output logic bit_clock_o,
    output logic up_level_o,
    output logic dn_level_o,
    output logic [4:0] slot_o,
    output logic [2:0] bit_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Released lines rest at the pull-up level
    assign up_level_o = up_oe_i ? up_drv_i : 1'b1;
    assign dn_level_o = dn_oe_i ? dn_drv_i : 1'b1;
    // Clock finishes the current frame, then idles while run_i is low
    initial begin
        frame_sync_o = 1'b0;
        bit_clock_o = 1'b0;
        slot_o = 5'h00;
        bit_o = 3'h0;
        forever begin
            wait (run_i);
            for (int k = 0; k < 256; k++) begin
                slot_o = 5'(k / 8);
                bit_o = 3'(k % 8);
                frame_sync_o = (k == 0);
                bit_clock_o = 1'b1;
                #62.5;
                bit_clock_o = 1'b0;
                #62.5;
            end
        end
    end
endmodule // tdm_far_side_model
`default_nettype wire

// file: testbench/tdm_slot_routing_config_tb.sv
// Self-checking bench for the slot routing configuration block
`default_nettype none
module tdm_slot_routing_config_tb
    import tdm_cfg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] dw = 32'h0;
    logic [31:0] dr;
    logic ack, run = 1'b0, tx = 1'b0, up_o, up_oe, dn_o, dn_oe, fs_oe, dc_oe, awd, st1, st2, sva;
    logic frame_sync, bclk, up_lvl, dn_lvl;
    logic [4:0] slot;
    logic [2:0] bitn;
    logic [7:0] q;
    int n_fail = 0;
    int check_count = 0;
    always #5 clk = ~clk;
    always @(posedge clk) tx <= ~tx;
    tdm_slot_routing_config i_tdm_slot_routing_config (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dw), .wb_dat_o(dr),
        .wb_ack_o(ack), .chan_select_pins_i(3'h5), .frame_sync_i(frame_sync), .bus_data_clock_i(bclk),
        .bit_clock_i(bclk), .upstream_line_i(up_lvl), .downstream_line_i(dn_lvl), .up_tx_data_i(tx),
        .down_tx_data_i(~tx), .terminal_mode_i(1'b0), .dc_is_input_i(1'b1), .upstream_line_o(up_o),
        .upstream_line_oe_o(up_oe), .downstream_line_o(dn_o), .downstream_line_oe_o(dn_oe),
        .frame_sync_oe_o(fs_oe), .bus_data_clock_oe_o(dc_oe), .activation_req_o(), .strobe_one_o(st1),
        .strobe_two_o(st2), .bit_clock_out_o(), .bit_clock_double_o(), .awake_disable_o(awd),
        .bchan_octet1_act_o(), .bchan_octet2_act_o(), .bchan_short_act_o(), .bchan_rx_o(), .dchan_act_o(),
        .dchan_rx_o(), .code0_act_o(), .code0_rx_o(), .code1_act_o(), .code1_rx_o(),
        .supervision_act_o(sva), .supervision_rx_o(), .arbitration_slot_o());
    tdm_far_side_model i_tdm_far_side_model (.run_i(run), .up_drv_i(up_o), .up_oe_i(up_oe), .dn_drv_i(dn_o),
        .dn_oe_i(dn_oe), .frame_sync_o(frame_sync), .bit_clock_o(bclk), .up_level_o(up_lvl), .dn_level_o(dn_lvl),
        .slot_o(slot), .bit_o(bitn));
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
        check_count++;
        if (s !== e) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask
    // Held until ack, then one idle cycle
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dw <= {24'h000000, d};
        @(posedge clk);
        while (ack !== 1'b1 && n < 50) begin
            @(posedge clk);
            n++;
        end
        q = dr[7:0];
        if (n >= 50) begin
            n_fail++;
            end_sim();
        end
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk("register", e, q);
    endtask
    initial begin
        repeat (100000) @(posedge clk);
        n_fail++;
        end_sim();
    end
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        rd(OFS_STROBE_ONE, RST_STROBE);
        rd(OFS_BCHAN, RST_BCHAN | 8'h05);
        rd(OFS_DCHAN_CI1, RST_DCHAN_CI1 | 8'h05);
        rd(OFS_SUPERVISION, RST_SUPERVISION | 8'h05);
        rd(OFS_BUS_GLOBAL, RST_BUS_GLOBAL);
        rd(8'h7F, 8'h00);
        bus(1'b1, OFS_BCHAN, 8'hBA);
        rd(OFS_BCHAN, 8'hBA);
        bus(1'b1, OFS_DCHAN_CI1, 8'h5B);
        bus(1'b1, OFS_BUS_GLOBAL, 8'h28);
        rd(OFS_DCHAN_CI1, 8'h03);
        bus(1'b1, OFS_DCHAN_CI1, 8'hF6);
        rd(OFS_DCHAN_CI1, 8'h06);
        bus(1'b1, OFS_BUS_GLOBAL, 8'h00);
        rd(OFS_DCHAN_CI1, 8'h5B);
        // Strobe one: slots 2,3 and short of 5; two: slot 11
        bus(1'b1, OFS_STROBE_ONE, 8'hE2);
        bus(1'b1, OFS_STROBE_TWO, 8'h4A);
        bus(1'b1, OFS_SUPERVISION, 8'h41);
        run <= 1'b1;
        for (int i = 0; i < 512; i++) begin
            @(posedge bclk);
            if (i == 300) run <= 1'b0;
            if (i >= 256 && bitn == 3'h4) begin
                chk("strobe_one", {7'h00, slot == 5'h02 || slot == 5'h03}, {7'h00, st1});
                chk("strobe_two", {7'h00, slot == 5'h0B}, {7'h00, st2});
                chk("supervision", {7'h00, slot == 5'h07}, {7'h00, sva});
            end
        end
        bus(1'b1, OFS_BUS_GLOBAL, 8'h80);
        repeat (4) @(posedge clk);
        chk("upstream", 8'h00, {7'h00, up_lvl});
        bus(1'b1, OFS_BUS_GLOBAL, 8'h49);
        repeat (4) @(posedge clk);
        chk("sync_clock_oe", 8'h00, {6'h00, fs_oe, dc_oe});
        chk("awake", 8'h01, {7'h00, awd});
        bus(1'b1, OFS_BUS_GLOBAL, 8'h02);
        repeat (4) @(posedge clk);
        chk("drive_oe", 8'h03, {6'h00, up_oe, dn_oe});
        end_sim();
    end
endmodule // tdm_slot_routing_config_tb
`default_nettype wire
